// ### logic/wgdf_unit.sv
`timescale 1ns/100ps

module wgdf_unit
  import wgdf_pkg::*;
#(
  parameter int SRC_N = wgdf_pkg::NUM_SRC
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic [wgdf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [wgdf_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [wgdf_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                     write_gate_in,
  input  wire logic                     arm_electronics_error,
  input  wire logic                     proc_fault_evt,
  input  wire logic                     seq_fault_evt,
  input  wire logic                     servo_timing_mark_missing,
  input  wire logic                     index_addr_fault_evt,
  input  wire logic                     shock_evt,
  output logic                          qualified_write_gate,
  output logic                          fault_output_pin_o,
  output logic                          fault_output_pin_oe
);
  import wgdf_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] drive_fault_config;
  logic [DATA_W-1:0] write_gate_fault_masks;
  logic [SRC_N-1:0]  drive_fault_pending;
  logic [SRC_N-1:0]  fault_set;
  logic [SRC_N-1:0]  fault_clr;
  logic [SRC_N-1:0]  flt_mask;
  logic [SRC_N-1:0]  wd_mask;
  logic [CFG_BLANK_W-1:0] blank_time;
  logic [CFG_BLANK_W-1:0] blank_cnt;
  wgdf_blank_t       blank_st;
  wgdf_blank_t       next_blank_st;
  logic              wg_act;
  logic              wg_act_d;
  logic              wg_rise;
  logic              arm_level;
  logic              arm_live;
  logic              arm_wr_evt;
  logic              arm_rd_evt;
  logic              wr_config;
  logic              wr_masks;
  logic              wr_pending;
  logic              wr_kill;
  logic              flt_any;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Writes to any other address are ignored
  assign wr_config  = reg_wr && (reg_addr == ADDR_CONFIG);
  assign wr_masks   = reg_wr && (reg_addr == ADDR_MASKS);
  assign wr_pending = reg_wr && (reg_addr == ADDR_PENDING);

  // Configuration, reserved bits 15..14 kept at zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_fault_config <= CONFIG_RST;
    end else if (wr_config) begin
      drive_fault_config <= reg_wdata & CONFIG_RW;
    end
  end

  // Masks, reserved bits 15 and 7 kept at zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_gate_fault_masks <= MASKS_RST;
    end else if (wr_masks) begin
      write_gate_fault_masks <= reg_wdata & MASKS_RW;
    end
  end

  // Field views of the two control registers
  assign flt_mask   = write_gate_fault_masks[MSK_FLT_LSB +: SRC_N];
  assign wd_mask    = write_gate_fault_masks[MSK_WD_LSB +: SRC_N];
  assign blank_time = drive_fault_config[CFG_BLANK_LSB +: CFG_BLANK_W];

  // Read data valid only in the cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CONFIG:  reg_rdata <= drive_fault_config;
        ADDR_MASKS:   reg_rdata <= write_gate_fault_masks;
        ADDR_PENDING: reg_rdata <= {{(DATA_W-SRC_N){1'b0}}, drive_fault_pending};
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Input polarity
  // ----------------------------------------------------------------
  // Write gate polarity from bit 10
  assign wg_act = write_gate_in ^ drive_fault_config[CFG_WG_IN_NEG];

  // XOR stage inverts for active low input unless bypassed
  always_comb begin
    if (drive_fault_config[CFG_ARM_NOXOR]) begin
      arm_level = arm_electronics_error;
    end else begin
      arm_level = arm_electronics_error ^ drive_fault_config[CFG_ARM_NEG];
    end
  end

  // Previous write gate for the activation edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wg_act_d <= 1'b0;
    end else begin
      wg_act_d <= wg_act;
    end
  end

  assign wg_rise = wg_act && !wg_act_d;

  // ----------------------------------------------------------------
  // Arm electronics error blanking
  // ----------------------------------------------------------------
  // Head settle after write gate can flag spurious errors, so hide them
  always_comb begin
    case (blank_st)
      WGDF_IDLE: begin
        if (wg_rise && (blank_time != '0)) begin
          next_blank_st = WGDF_BLANK;
        end else if (wg_act) begin
          next_blank_st = WGDF_ARMED;
        end else begin
          next_blank_st = WGDF_IDLE;
        end
      end
      WGDF_BLANK: begin
        if (!wg_act) begin
          next_blank_st = WGDF_IDLE;
        end else if (blank_cnt == 8'h01) begin
          next_blank_st = WGDF_ARMED;
        end else begin
          next_blank_st = WGDF_BLANK;
        end
      end
      WGDF_ARMED: begin
        next_blank_st = wg_act ? WGDF_ARMED : WGDF_IDLE;
      end
      default: next_blank_st = WGDF_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blank_st <= WGDF_IDLE;
    end else begin
      blank_st <= next_blank_st;
    end
  end

  // Counter loaded at activation, one count per system clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blank_cnt <= '0;
    end else if (blank_st == WGDF_IDLE && wg_rise) begin
      blank_cnt <= blank_time;
    end else if (blank_st == WGDF_BLANK && blank_cnt != '0) begin
      blank_cnt <= blank_cnt - 8'h01;
    end
  end

  // Error counts only once armed; the activation cycle is ignored unless blanking is zero
  assign arm_live   = (blank_st == WGDF_ARMED) ||
                      (blank_st == WGDF_IDLE && wg_rise && blank_time == '0);
  assign arm_wr_evt = arm_level && wg_act && arm_live;
  assign arm_rd_evt = arm_level && !wg_act;

  // ----------------------------------------------------------------
  // Fault sources and pending latches
  // ----------------------------------------------------------------
  // Missing mark always counts during writes, on reads only if enabled
  always_comb begin
    fault_set               = '0;
    fault_set[SRC_ARM_RD]    = arm_rd_evt;
    fault_set[SRC_ARM_WR]    = arm_wr_evt;
    fault_set[SRC_SHOCK]     = shock_evt && wg_act;
    fault_set[SRC_IDX_ADDR]  = index_addr_fault_evt;
    fault_set[SRC_MARK_MISS] = servo_timing_mark_missing &&
                               (wg_act || drive_fault_config[CFG_MARK_RD]);
    fault_set[SRC_SEQ]      = seq_fault_evt;
    fault_set[SRC_PROC]     = proc_fault_evt;
  end

  assign fault_clr = wr_pending ? reg_wdata[SRC_N-1:0] : '0;

  generate
    for (genvar i = 0; i < SRC_N; i++) begin : g_latch
      wgdf_fault_latch u_latch (
        .clk     (clk),
        .sys_rst (sys_rst),
        .set_evt (fault_set[i]),
        .clr_req (fault_clr[i]),
        .held    (drive_fault_pending[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wr_kill = |(drive_fault_pending & wd_mask);
  assign flt_any = |(drive_fault_pending & flt_mask);

  // Gate off a write while any enabled fault is latched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      qualified_write_gate <= 1'b0;
    end else begin
      qualified_write_gate <= (wg_act && !wr_kill) ^ drive_fault_config[CFG_QWG_NEG];
    end
  end

  // Fault level stays up until software clears the latches
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_output_pin_o <= 1'b0;
    end else begin
      fault_output_pin_o <= flt_any;
    end
  end

  // Pin stays undriven unless software enables it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_output_pin_oe <= 1'b0;
    end else begin
      fault_output_pin_oe <= drive_fault_config[CFG_PIN_OE];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_proc_latch_set: assert property (
    proc_fault_evt |=> drive_fault_pending[SRC_PROC]
  ) else $error("processor fault not latched");

  chk_w1c_clears_latch: assert property (
    wr_pending && reg_wdata[SRC_SEQ] && !seq_fault_evt |=> !drive_fault_pending[SRC_SEQ]
  ) else $error("sequencer latch not cleared by write one");

  // Drive fault pin follows the enabled latches
  chk_fault_pin_level: assert property (
    |(drive_fault_pending & flt_mask) |=> fault_output_pin_o
  ) else $error("enabled fault did not raise fault pin");

  chk_fault_pin_quiet: assert property (
    !(|(drive_fault_pending & flt_mask)) |=> !fault_output_pin_o
  ) else $error("fault pin high with no enabled latch");

  chk_wg_forced_off: assert property (
    |(drive_fault_pending & wd_mask) |=> qualified_write_gate == $past(drive_fault_config[CFG_QWG_NEG])
  ) else $error("write gate not forced inactive");

  chk_pin_oe_follows: assert property (
    ##1 fault_output_pin_oe == $past(drive_fault_config[CFG_PIN_OE])
  ) else $error("fault pin enable does not follow config");

  chk_wg_polarity: assert property (
    (write_gate_in != drive_fault_config[CFG_WG_IN_NEG]) && !(|(drive_fault_pending & wd_mask))
    |=> qualified_write_gate != $past(drive_fault_config[CFG_QWG_NEG])
  ) else $error("qualified write gate wrong polarity");

  chk_wg_in_idle: assert property (
    (write_gate_in == drive_fault_config[CFG_WG_IN_NEG])
    |=> qualified_write_gate == $past(drive_fault_config[CFG_QWG_NEG])
  ) else $error("inactive write gate passed through");

  // Polarity stage on the arm electronics error
  chk_arm_bypass: assert property (
    drive_fault_config[CFG_ARM_NOXOR] && drive_fault_config[CFG_ARM_NEG] &&
    arm_electronics_error && !wg_act |=> drive_fault_pending[SRC_ARM_RD]
  ) else $error("bypassed error input not latched");

  chk_arm_neg_level: assert property (
    !drive_fault_config[CFG_ARM_NOXOR] && drive_fault_config[CFG_ARM_NEG] &&
    !arm_electronics_error && !wg_act |=> drive_fault_pending[SRC_ARM_RD]
  ) else $error("active low error not latched");

  // Blanking window after write gate activation
  chk_blank_holds: assert property (
    blank_st == WGDF_BLANK && !wr_pending |=>
    drive_fault_pending[SRC_ARM_WR] == $past(drive_fault_pending[SRC_ARM_WR])
  ) else $error("write error latched inside blanking");

  // Activation cycle plus three blank cycles, armed on the next
  chk_blank_start: assert property (
    blank_st == WGDF_IDLE && wg_rise && blank_time == 8'h03 ##1 wg_act [*3]
    |=> blank_st == WGDF_ARMED
  ) else $error("blanking length wrong");

  // Missing timing mark: always on writes, on reads only when enabled
  chk_mark_on_write: assert property (
    servo_timing_mark_missing && wg_act |=> drive_fault_pending[SRC_MARK_MISS]
  ) else $error("missing mark on write not latched");

  chk_mark_read_on: assert property (
    servo_timing_mark_missing && !wg_act && drive_fault_config[CFG_MARK_RD] |=> drive_fault_pending[SRC_MARK_MISS]
  ) else $error("missing mark on read not latched");

  chk_mark_read_off: assert property (
    servo_timing_mark_missing && !wg_act && !drive_fault_config[CFG_MARK_RD] &&
    !drive_fault_pending[SRC_MARK_MISS] |=> !drive_fault_pending[SRC_MARK_MISS]
  ) else $error("missing mark on read latched while disabled");

  chk_shock_read_quiet: assert property (
    shock_evt && !wg_act && !drive_fault_pending[SRC_SHOCK] |=> !drive_fault_pending[SRC_SHOCK]
  ) else $error("shock latched outside a write");

  cov_blank_then_error: cover property (blank_st == WGDF_BLANK ##[1:20] arm_wr_evt);
  cov_write_killed: cover property (wg_act && wr_kill);
  cov_set_and_clear: cover property (|(fault_set & fault_clr));
  cov_pin_driven: cover property (fault_output_pin_oe && fault_output_pin_o);

endmodule : wgdf_unit

// ### logic/wgdf_pkg.sv
package wgdf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 16;
  localparam int          NUM_SRC       = 7;
  localparam logic [15:0] ADDR_CONFIG   = 16'hE044;
  localparam logic [15:0] ADDR_MASKS    = 16'hE045;
  localparam logic [15:0] ADDR_PENDING  = 16'hE046;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CONFIG_RST    = 16'h0000;
  localparam logic [15:0] MASKS_RST     = 16'h0000;
  localparam logic [6:0]  PENDING_RST   = 7'h00;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int          CFG_BLANK_LSB = 0;
  localparam int          CFG_BLANK_W   = 8;
  localparam int          CFG_ARM_NEG   = 8;
  localparam int          CFG_ARM_NOXOR = 9;
  localparam int          CFG_WG_IN_NEG = 10;
  localparam int          CFG_QWG_NEG   = 11;
  localparam int          CFG_PIN_OE    = 12;
  localparam int          CFG_MARK_RD   = 13;
  localparam logic [15:0] CONFIG_RW     = 16'h3FFF;

  // ----------------------------------------------------------------
  // Mask fields and source order in pending
  // ----------------------------------------------------------------
  localparam int          MSK_FLT_LSB   = 0;
  localparam int          MSK_WD_LSB    = 8;
  localparam logic [15:0] MASKS_RW      = 16'h7F7F;
  localparam int          SRC_ARM_RD    = 0;
  localparam int          SRC_ARM_WR    = 1;
  localparam int          SRC_SHOCK     = 2;
  localparam int          SRC_IDX_ADDR  = 3;
  localparam int          SRC_MARK_MISS = 4;
  localparam int          SRC_SEQ       = 5;
  localparam int          SRC_PROC      = 6;

  // ----------------------------------------------------------------
  // Blanking sequence, Gray coded along idle, blank, armed
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WGDF_IDLE  = 2'b00,
    WGDF_BLANK = 2'b01,
    WGDF_ARMED = 2'b11
  } wgdf_blank_t;

endpackage : wgdf_pkg

// ### logic/wgdf_fault_latch.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------
// One sticky fault latch, set dominant over a write-one clear
// ------------------------------------------------------------------
module wgdf_fault_latch (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic set_evt,
  input  wire logic clr_req,
  output logic      held
);
  import wgdf_pkg::*;

  // Set wins so an event in the clearing cycle is never lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      held <= 1'b0;
    end else if (set_evt) begin
      held <= 1'b1;
    end else if (clr_req) begin
      held <= 1'b0;
    end
  end

endmodule : wgdf_fault_latch

// ### sim/wgdf_drive_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Arm electronics and write channel, seen from the unit's pins
// ----------------------------------------------------------------
module wgdf_drive_model (
  input  wire logic wg_act,
  input  wire logic err_act,
  input  wire logic wg_neg,
  input  wire logic arm_neg,
  input  wire logic arm_noxor,
  output logic      write_gate_in,
  output logic      arm_electronics_error
);
  // Gate level follows the polarity the unit is set to expect
  assign write_gate_in = wg_act ^ wg_neg;
  // Inversion only while the polarity stage is in use; bypass means raw active high
  assign arm_electronics_error = err_act ^ (arm_neg & ~arm_noxor);
endmodule : wgdf_drive_model

// ### sim/test_write_gate_drive_fault_unit.sv
`timescale 1ns/100ps

module test_write_gate_drive_fault_unit;
  import wgdf_pkg::*;

  logic        clk;
  logic        sys_rst;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        wg_act;
  logic        err_act;
  logic        wg_neg;
  logic        arm_neg;
  logic        arm_noxor;
  logic [6:0]  evt;
  logic        write_gate_in;
  logic        arm_electronics_error;
  logic        qwg;
  logic        pin_o;
  logic        pin_oe;
  logic [15:0] d;
  int          failures;
  int          samples_checked;
  int          cycles;

  wgdf_unit wgdf_unit_i (
    .clk                       (clk),
    .sys_rst                   (sys_rst),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .write_gate_in             (write_gate_in),
    .arm_electronics_error     (arm_electronics_error),
    .proc_fault_evt            (evt[SRC_PROC]),
    .seq_fault_evt             (evt[SRC_SEQ]),
    .servo_timing_mark_missing (evt[SRC_MARK_MISS]),
    .index_addr_fault_evt      (evt[SRC_IDX_ADDR]),
    .shock_evt                 (evt[SRC_SHOCK]),
    .qualified_write_gate      (qwg),
    .fault_output_pin_o        (pin_o),
    .fault_output_pin_oe       (pin_oe)
  );

  wgdf_drive_model wgdf_drive_model_i (
    .wg_act                (wg_act),
    .err_act               (err_act),
    .wg_neg                (wg_neg),
    .arm_neg               (arm_neg),
    .arm_noxor             (arm_noxor),
    .write_gate_in         (write_gate_in),
    .arm_electronics_error (arm_electronics_error)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks made %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
    end
  endtask : check

  task automatic check_bit(input string what, input logic got, input logic exp);
    check(what, {15'h0000, got}, {15'h0000, exp});
  endtask : check_bit

  task automatic reg_write(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [15:0] addr, output logic [15:0] data);
    @(posedge clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    data = reg_rdata;
  endtask : reg_read

  // Keeps the model's polarity in step with what the unit is told
  task automatic set_cfg(input logic [15:0] data);
    reg_write(ADDR_CONFIG, data);
    wg_neg    <= data[CFG_WG_IN_NEG];
    arm_neg   <= data[CFG_ARM_NEG];
    arm_noxor <= data[CFG_ARM_NOXOR];
  endtask : set_cfg

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic fire(input int b);
    @(posedge clk);
    evt[b] <= 1'b1;
    @(posedge clk);
    evt[b] <= 1'b0;
    settle();
  endtask : fire

  task automatic pend_is(input logic [15:0] exp);
    reg_read(ADDR_PENDING, d);
    check("pending", d, exp);
  endtask : pend_is

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    reg_read(ADDR_CONFIG, d);
    check("config reset", d, CONFIG_RST);
    reg_read(ADDR_MASKS, d);
    check("masks reset", d, MASKS_RST);
    pend_is(16'h0000);
    check_bit("pin enable reset", pin_oe, 1'b0);
    set_cfg(16'hFFFF);
    reg_read(ADDR_CONFIG, d);
    check("config bits", d, CONFIG_RW);
    check_bit("pin enable on", pin_oe, 1'b1);
    reg_write(ADDR_MASKS, 16'hFFFF);
    reg_read(ADDR_MASKS, d);
    check("mask bits", d, MASKS_RW);
    reg_write(ADDR_PENDING, 16'hFFFF);
    pend_is(16'h0000);
    reg_write(16'hE047, 16'hFFFF);
    reg_read(16'hE047, d);
    check("unmapped read", d, 16'h0000);
    set_cfg(16'h0000);
    settle();
    check_bit("pin enable off", pin_oe, 1'b0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_sources();
    int srcs[3] = '{SRC_PROC, SRC_SEQ, SRC_IDX_ADDR};
    reg_write(ADDR_MASKS, 16'h007F);
    foreach (srcs[i]) begin
      fire(srcs[i]);
      pend_is(16'h0001 << srcs[i]);
      check_bit("fault pin set", pin_o, 1'b1);
      reg_write(ADDR_PENDING, 16'h0001 << srcs[i]);
      pend_is(16'h0000);
      check_bit("fault pin cleared", pin_o, 1'b0);
    end
    reg_write(ADDR_MASKS, 16'h0000);
    fire(SRC_PROC);
    pend_is(16'h0040);
    check_bit("masked fault pin", pin_o, 1'b0);
    reg_write(ADDR_PENDING, 16'h0040);
    $display("test sources done");
  endtask : t_sources

  task automatic t_write_gate();
    reg_write(ADDR_MASKS, 16'h4000);
    @(posedge clk);
    wg_act <= 1'b1;
    settle();
    check_bit("gate passes", qwg, 1'b1);
    fire(SRC_SEQ);
    check_bit("unmasked source", qwg, 1'b1);
    reg_write(ADDR_PENDING, 16'h0020);
    fire(SRC_PROC);
    check_bit("gate forced off", qwg, 1'b0);
    reg_write(ADDR_PENDING, 16'h0040);
    settle();
    check_bit("gate restored", qwg, 1'b1);
    set_cfg(16'h0800);
    settle();
    check_bit("active low output", qwg, 1'b0);
    set_cfg(16'h0C00);
    settle();
    check_bit("active low input", qwg, 1'b0);
    @(posedge clk);
    wg_act <= 1'b0;
    settle();
    check_bit("inactive low input", qwg, 1'b1);
    set_cfg(16'h0000);
    reg_write(ADDR_MASKS, 16'h0000);
    $display("test write gate done");
  endtask : t_write_gate

  task automatic t_blank();
    logic [15:0] cfgs[4] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300};
    set_cfg(16'h0003);
    @(posedge clk);
    wg_act  <= 1'b1;
    err_act <= 1'b1;
    repeat (4) @(posedge clk);
    err_act <= 1'b0;
    settle();
    pend_is(16'h0000);
    @(posedge clk);
    err_act <= 1'b1;
    @(posedge clk);
    err_act <= 1'b0;
    settle();
    pend_is(16'h0002);
    reg_write(ADDR_PENDING, 16'h0002);
    wg_act <= 1'b0;
    foreach (cfgs[i]) begin
      set_cfg(cfgs[i]);
      @(posedge clk);
      err_act <= 1'b1;
      @(posedge clk);
      err_act <= 1'b0;
      settle();
      pend_is(16'h0001);
      reg_write(ADDR_PENDING, 16'h0001);
      settle();
      pend_is(16'h0000);
    end
    $display("test blanking done");
  endtask : t_blank

  task automatic t_conditional();
    set_cfg(16'h0000);
    fire(SRC_SHOCK);
    fire(SRC_MARK_MISS);
    pend_is(16'h0000);
    set_cfg(16'h2000);
    fire(SRC_MARK_MISS);
    pend_is(16'h0010);
    reg_write(ADDR_PENDING, 16'h0010);
    set_cfg(16'h0000);
    wg_act <= 1'b1;
    fire(SRC_SHOCK);
    fire(SRC_MARK_MISS);
    pend_is(16'h0014);
    reg_write(ADDR_PENDING, 16'h0014);
    wg_act <= 1'b0;
    $display("test conditional done");
  endtask : t_conditional

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    wg_act = 1'b0;
    err_act = 1'b0;
    wg_neg = 1'b0;
    arm_neg = 1'b0;
    arm_noxor = 1'b0;
    evt = 7'h00;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_sources();
    t_write_gate();
    t_blank();
    t_conditional();
    print_verdict();
  end
endmodule : test_write_gate_drive_fault_unit
